// ===== logic/csp_core_regs.v
// core stack, data pointer, status word and accumulator registers
//
// Behaviour
// - stack pointer resets to 0x07
// - push increments pointer, then writes byte there
// - data pointer is high byte then low byte
// - data pointer addresses external and program memory
// - carry flag from add carry or subtract borrow
// - nibble carry from bit three carry/borrow
// - status bits five and one are user flags
// - status bits four:three select register bank
// - signed overflow on add, add-carry, subtract
// - overflow when product exceeds 255
// - overflow on divide by zero
// - arithmetic clears overflow otherwise
// - status bit zero shows accumulator parity
// - accumulator holds arithmetic results, resets zero
// - status word at 0xd0, resets zero
// - data pointer high at 0x83 always
// - undefined addresses are reserved, no function
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "csp_defines.vh"

module csp_core_regs #(
    parameter ADR_W = 10
)(
    // clock and reset
    input  wire             clock_in,
    input  wire             rst_in,
    // wishbone classic slave
    input  wire             wb_cyc_in,
    input  wire             wb_stb_in,
    input  wire             wb_we_in,
    input  wire [ADR_W-1:0] wb_adr_in,
    input  wire [3:0]       wb_sel_in,
    input  wire [31:0]      wb_dat_in,
    output wire [31:0]      wb_dat_out,
    output wire             wb_ack_out,
    // instruction datapath operations
    input  wire             op_valid_in,
    input  wire [2:0]       op_code_in,
    input  wire [7:0]       op_operand_in,
    input  wire [7:0]       push_data_in,
    // stack memory access
    output wire             stack_wr_en_out,
    output wire             stack_rd_en_out,
    output wire [7:0]       stack_addr_out,
    output wire [7:0]       stack_wr_data_out,
    // register state towards the core
    output wire [15:0]      data_pointer_full_out,
    output wire [7:0]       bank_base_out,
    output wire [7:0]       stack_top_pointer_out,
    output wire [7:0]       program_status_word_out,
    output wire [7:0]       arith_result_reg_out,
    output wire [7:0]       mul_div_high_out
);

    // architectural registers
    reg [7:0]  stack_top_pointer_r;
    reg [7:0]  stack_top_pointer_nxt;
    reg [7:0]  data_pointer_low_r;
    reg [7:0]  data_pointer_low_nxt;
    reg [7:0]  data_pointer_high_r;
    reg [7:0]  data_pointer_high_nxt;
    reg [7:0]  program_status_word_r;
    reg [7:0]  program_status_word_nxt;
    reg [7:0]  arith_result_reg_r;
    reg [7:0]  arith_result_reg_nxt;

    // derived and handshake registers
    reg [15:0] data_pointer_full_r;
    reg [7:0]  bank_base_r;
    reg [7:0]  mul_div_high_r;
    reg [7:0]  mul_div_high_nxt;
    reg        stack_wr_en_r;
    reg        stack_rd_en_r;
    reg [7:0]  stack_addr_r;
    reg [7:0]  stack_addr_nxt;
    reg [7:0]  stack_wr_data_r;
    reg        wb_ack_r;
    reg [31:0] wb_dat_r;
    reg [31:0] wb_dat_nxt;

    // bus decode
    wire       bus_req;
    wire       bus_wr;
    wire [7:0] bus_idx;
    wire [7:0] bus_byte;

    // arithmetic helpers
    wire [7:0] acc_a;
    wire [7:0] opnd_b;
    wire       cy_in;
    wire [8:0] add_sum;
    wire [4:0] add_low;
    wire [8:0] sub_dif;
    wire [4:0] sub_low;
    wire [15:0] mul_prod;
    wire [7:0] div_quot;
    wire [7:0] div_rem;
    wire       div_zero;

    // register values after any bus write, before the datapath op
    reg [7:0]  arith_result_reg_nxt_pre;
    reg [7:0]  psw_pre;

    // one request per transfer; ack low for the cycle after it was given
    assign bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_r;
    assign bus_wr   = bus_req & wb_we_in & wb_sel_in[0];
    assign bus_idx  = wb_adr_in[9:2];
    assign bus_byte = wb_dat_in[7:0];

    // operands follow a same-cycle bus write so software and core agree
    assign acc_a  = arith_result_reg_nxt_pre;
    assign opnd_b = op_operand_in;
    assign cy_in  = psw_pre[`CSP_PSW_CARRY];

    // nine-bit sums give carry and borrow, five-bit ones the nibble flag
    assign add_sum  = {1'b0, acc_a} + {1'b0, opnd_b}
                      + {8'h00, cy_in & (op_code_in == `CSP_OP_ADD_CARRY)};
    assign add_low  = {1'b0, acc_a[3:0]} + {1'b0, opnd_b[3:0]}
                      + {4'h0, cy_in & (op_code_in == `CSP_OP_ADD_CARRY)};
    assign sub_dif  = {1'b0, acc_a} - {1'b0, opnd_b} - {8'h00, cy_in};
    assign sub_low  = {1'b0, acc_a[3:0]} - {1'b0, opnd_b[3:0]}
                      - {4'h0, cy_in};
    assign mul_prod = acc_a * opnd_b;
    assign div_zero = (opnd_b == 8'h00);
    // divider result is forced to zero on a zero divisor, never x
    assign div_quot = div_zero ? 8'h00 : acc_a / opnd_b;
    assign div_rem  = div_zero ? 8'h00 : acc_a % opnd_b;

    // bus write merge, ahead of the datapath op
    always @*
    begin
        arith_result_reg_nxt_pre = arith_result_reg_r;
        psw_pre                  = program_status_word_r;
        if (bus_wr && bus_idx == `CSP_IDX_ARITH_RESULT)
            arith_result_reg_nxt_pre = bus_byte;
        // the parity bit is not writable; it is recomputed below
        if (bus_wr && bus_idx == `CSP_IDX_STATUS_WORD)
            psw_pre = {bus_byte[7:1], program_status_word_r[0]};
    end

    // bus writes first, then the datapath op overrides what it touches
    always @*
    begin
        stack_top_pointer_nxt   = stack_top_pointer_r;
        data_pointer_low_nxt    = data_pointer_low_r;
        data_pointer_high_nxt   = data_pointer_high_r;
        arith_result_reg_nxt    = arith_result_reg_nxt_pre;
        program_status_word_nxt = psw_pre;
        mul_div_high_nxt        = mul_div_high_r;
        stack_addr_nxt          = stack_addr_r;
        if (bus_wr)
        begin
            case (bus_idx)
                `CSP_IDX_STACK_TOP:
                    stack_top_pointer_nxt = bus_byte;
                `CSP_IDX_DATA_POINTER_FULL_LOW:
                    data_pointer_low_nxt = bus_byte;
                `CSP_IDX_DATA_POINTER_FULL_HIGH:
                    data_pointer_high_nxt = bus_byte;
                default:
                    stack_top_pointer_nxt = stack_top_pointer_r;
            endcase
        end
        if (op_valid_in)
        begin
            case (op_code_in)
                `CSP_OP_ADD, `CSP_OP_ADD_CARRY:
                begin
                    arith_result_reg_nxt = add_sum[7:0];
                    program_status_word_nxt[`CSP_PSW_CARRY] =
                        add_sum[8];
                    program_status_word_nxt[`CSP_PSW_NIBBLE] =
                        add_low[4];
                    program_status_word_nxt[`CSP_PSW_EXCESS] =
                        (acc_a[7] == opnd_b[7]) &&
                        (add_sum[7] != acc_a[7]);
                end
                `CSP_OP_SUB_BORROW:
                begin
                    arith_result_reg_nxt = sub_dif[7:0];
                    program_status_word_nxt[`CSP_PSW_CARRY] =
                        sub_dif[8];
                    program_status_word_nxt[`CSP_PSW_NIBBLE] =
                        sub_low[4];
                    program_status_word_nxt[`CSP_PSW_EXCESS] =
                        (acc_a[7] != opnd_b[7]) &&
                        (sub_dif[7] != acc_a[7]);
                end
                `CSP_OP_MULTIPLY:
                begin
                    arith_result_reg_nxt = mul_prod[7:0];
                    mul_div_high_nxt     = mul_prod[15:8];
                    program_status_word_nxt[`CSP_PSW_CARRY]  = 1'b0;
                    program_status_word_nxt[`CSP_PSW_NIBBLE] = 1'b0;
                    program_status_word_nxt[`CSP_PSW_EXCESS] =
                        (mul_prod[15:8] != 8'h00);
                end
                `CSP_OP_DIVIDE:
                begin
                    // a zero divisor leaves the accumulator as it was
                    if (!div_zero)
                    begin
                        arith_result_reg_nxt = div_quot;
                        mul_div_high_nxt     = div_rem;
                    end
                    program_status_word_nxt[`CSP_PSW_CARRY]  = 1'b0;
                    program_status_word_nxt[`CSP_PSW_NIBBLE] = 1'b0;
                    program_status_word_nxt[`CSP_PSW_EXCESS] =
                        div_zero;
                end
                `CSP_OP_PUSH:
                begin
                    // pointer moves up first, byte lands at the new top
                    stack_top_pointer_nxt = stack_top_pointer_r
                                            + 8'h01;
                    stack_addr_nxt        = stack_top_pointer_r
                                            + 8'h01;
                end
                `CSP_OP_POP:
                begin
                    stack_addr_nxt        = stack_top_pointer_r;
                    stack_top_pointer_nxt = stack_top_pointer_r
                                            - 8'h01;
                end
                default:
                    stack_addr_nxt = stack_addr_r;
            endcase
        end
        // parity always tracks the accumulator value being stored
        program_status_word_nxt[`CSP_PSW_PARITY] =
            ^arith_result_reg_nxt;
    end

    // bus read mux; reserved and unmapped addresses read zero
    always @*
    begin
        case (bus_idx)
            `CSP_IDX_STACK_TOP:
                wb_dat_nxt = {24'h000000, stack_top_pointer_r};
            `CSP_IDX_DATA_POINTER_FULL_LOW:
                wb_dat_nxt = {24'h000000, data_pointer_low_r};
            `CSP_IDX_DATA_POINTER_FULL_HIGH:
                wb_dat_nxt = {24'h000000, data_pointer_high_r};
            `CSP_IDX_STATUS_WORD:
                wb_dat_nxt = {24'h000000, program_status_word_r};
            `CSP_IDX_ARITH_RESULT:
                wb_dat_nxt = {24'h000000, arith_result_reg_r};
            default:
                wb_dat_nxt = 32'h00000000;
        endcase
    end

    // architectural state
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            stack_top_pointer_r   <= `CSP_RST_STACK_TOP;
            data_pointer_low_r    <= `CSP_RST_DATA_POINTER_FULL_LOW;
            data_pointer_high_r   <= `CSP_RST_DATA_POINTER_FULL_HIGH;
            program_status_word_r <= `CSP_RST_STATUS_WORD;
            arith_result_reg_r    <= `CSP_RST_ARITH_RESULT;
            mul_div_high_r        <= 8'h00;
        end
        else
        begin
            stack_top_pointer_r   <= stack_top_pointer_nxt;
            data_pointer_low_r    <= data_pointer_low_nxt;
            data_pointer_high_r   <= data_pointer_high_nxt;
            program_status_word_r <= program_status_word_nxt;
            arith_result_reg_r    <= arith_result_reg_nxt;
            mul_div_high_r        <= mul_div_high_nxt;
        end
    end

    // derived outputs, registered alongside the state they mirror
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            data_pointer_full_r <= {`CSP_RST_DATA_POINTER_FULL_HIGH, `CSP_RST_DATA_POINTER_FULL_LOW};
            bank_base_r         <= 8'h00;
        end
        else
        begin
            data_pointer_full_r <= {data_pointer_high_nxt,
                                    data_pointer_low_nxt};
            bank_base_r <= {3'b000,
                program_status_word_nxt[`CSP_PSW_BANK_HI:`CSP_PSW_BANK_LO],
                3'b000};
        end
    end

    // stack memory strobes, one cycle each
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            stack_wr_en_r   <= 1'b0;
            stack_rd_en_r   <= 1'b0;
            stack_addr_r    <= 8'h00;
            stack_wr_data_r <= 8'h00;
        end
        else
        begin
            stack_wr_en_r   <= op_valid_in &&
                               (op_code_in == `CSP_OP_PUSH);
            stack_rd_en_r   <= op_valid_in &&
                               (op_code_in == `CSP_OP_POP);
            stack_addr_r    <= stack_addr_nxt;
            if (op_valid_in && op_code_in == `CSP_OP_PUSH)
                stack_wr_data_r <= push_data_in;
        end
    end

    // wishbone answer: ack one cycle after the request, every address
    always @(posedge clock_in)
    begin
        if (rst_in)
        begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h00000000;
        end
        else
        begin
            wb_ack_r <= bus_req;
            if (bus_req && !wb_we_in)
                wb_dat_r <= wb_dat_nxt;
        end
    end

    // outputs, all from flip-flops
    assign wb_ack_out              = wb_ack_r;
    assign wb_dat_out              = wb_dat_r;
    assign stack_wr_en_out         = stack_wr_en_r;
    assign stack_rd_en_out         = stack_rd_en_r;
    assign stack_addr_out          = stack_addr_r;
    assign stack_wr_data_out       = stack_wr_data_r;
    assign data_pointer_full_out   = data_pointer_full_r;
    assign bank_base_out           = bank_base_r;
    assign stack_top_pointer_out   = stack_top_pointer_r;
    assign program_status_word_out = program_status_word_r;
    assign arith_result_reg_out    = arith_result_reg_r;
    assign mul_div_high_out        = mul_div_high_r;

endmodule

// ===== logic/csp_defines.vh
// register indices, field positions, reset values and op codes
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define CSP_IDX_STACK_TOP     8'h81
`define CSP_IDX_DATA_POINTER_FULL_LOW      8'h82
`define CSP_IDX_DATA_POINTER_FULL_HIGH     8'h83
`define CSP_IDX_STATUS_WORD   8'hd0
`define CSP_IDX_ARITH_RESULT  8'he0

// addresses listed as reserved; decoded like any unmapped address
`define CSP_IDX_RSVD_A        8'h97
`define CSP_IDX_RSVD_B        8'hce
`define CSP_IDX_RSVD_C        8'hdf

// reset values
`define CSP_RST_STACK_TOP     8'h07
`define CSP_RST_DATA_POINTER_FULL_LOW      8'h00
`define CSP_RST_DATA_POINTER_FULL_HIGH     8'h00
`define CSP_RST_STATUS_WORD   8'h00
`define CSP_RST_ARITH_RESULT  8'h00

// status word fields
`define CSP_PSW_CARRY         7
`define CSP_PSW_NIBBLE        6
`define CSP_PSW_USER0         5
`define CSP_PSW_BANK_HI       4
`define CSP_PSW_BANK_LO       3
`define CSP_PSW_EXCESS        2
`define CSP_PSW_USER1         1
`define CSP_PSW_PARITY        0

// datapath operation codes
`define CSP_OP_NONE           3'h0
`define CSP_OP_ADD            3'h1
`define CSP_OP_ADD_CARRY      3'h2
`define CSP_OP_SUB_BORROW     3'h3
`define CSP_OP_MULTIPLY       3'h4
`define CSP_OP_DIVIDE         3'h5
`define CSP_OP_PUSH           3'h6
`define CSP_OP_POP            3'h7

`endif

// ===== verif/csp_core_regs_properties.sv
// concurrent checks on the core pointer and status register ports
`timescale 1ns/1ps
`include "csp_defines.vh"
module csp_core_regs_props #(
    parameter ADR_W = 10
)(
    // bus side
    input wire             clock_in, rst_in, wb_cyc_in, wb_stb_in,
    input wire             wb_we_in, wb_ack_out,
    input wire [ADR_W-1:0] wb_adr_in,
    input wire [3:0]       wb_sel_in,
    input wire [31:0]      wb_dat_in, wb_dat_out,
    // datapath and register state
    input wire             op_valid_in, stack_wr_en_out, stack_rd_en_out,
    input wire [2:0]       op_code_in,
    input wire [7:0]       op_operand_in, push_data_in, stack_addr_out,
    input wire [7:0]       stack_wr_data_out, bank_base_out, mul_div_high_out,
    input wire [7:0]       stack_top_pointer_out, program_status_word_out,
    input wire [7:0]       arith_result_reg_out,
    input wire [15:0]      data_pointer_full_out
);
    // ops are judged only when no bus write lands on the same edge
    wire        wr_now = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
    wire        op_ok  = op_valid_in & ~wr_now;
    wire [7:0]  sp     = stack_top_pointer_out;
    wire [7:0]  program_status_word    = program_status_word_out;
    wire [7:0]  acc    = arith_result_reg_out;
    wire [15:0] prod   = acc * op_operand_in;
    wire [8:0]  sum    = acc + op_operand_in;
    wire        add_ov = (acc[7] == op_operand_in[7]) & (sum[7] != acc[7]);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    rst_sp_a: assert property ($fell(rst_in) |-> sp == 8'h07)
        else $error("stack pointer not 07 after reset");
    push_order_a: assert property (op_ok && op_code_in == `CSP_OP_PUSH |=>
        stack_wr_en_out && sp == $past(sp) + 8'h01 && stack_addr_out == sp)
        else $error("push did not write above old pointer");
    pop_order_a: assert property (op_ok && op_code_in == `CSP_OP_POP |=>
        stack_rd_en_out && stack_addr_out == $past(sp) && sp == $past(sp) - 8'h01)
        else $error("pop did not read at old pointer");
    data_pointer_full_join_a: assert property (wr_now && wb_sel_in[0] && wb_adr_in == 10'h208
        |=> data_pointer_full_out == {$past(data_pointer_full_out[15:8]),
        $past(wb_dat_in[7:0])}) else $error("low pointer byte misplaced");
    parity_live_a: assert property (program_status_word[0] == ^acc)
        else $error("parity bit wrong");
    bank_map_a: assert property ($stable(program_status_word[4:3]) |->
        bank_base_out == {3'h0, program_status_word[4:3], 3'h0}) else $error("bank base wrong");
    add_flags_a: assert property (op_ok && op_code_in == `CSP_OP_ADD |=>
        program_status_word[7] == $past(sum[8]) && program_status_word[2] == $past(add_ov))
        else $error("add flags wrong");
    mul_excess_a: assert property (op_ok && op_code_in == `CSP_OP_MULTIPLY |=>
        program_status_word[2] == $past(prod > 16'h00ff)) else $error("multiply overflow wrong");
    div_zero_a: assert property (op_ok && op_code_in == `CSP_OP_DIVIDE &&
        op_operand_in == 8'h00 |=> program_status_word[2] && $stable(acc))
        else $error("divide by zero mishandled");
    flags_hold_a: assert property (!wr_now && !(op_valid_in && op_code_in >= 3'h1
        && op_code_in <= 3'h5) |=> $stable({program_status_word[7:6], program_status_word[2]}))
        else $error("flags moved without arithmetic");
endmodule

bind csp_core_regs csp_core_regs_props #(.ADR_W(ADR_W)) props_u (
    .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .op_valid_in(op_valid_in),
    .stack_wr_en_out(stack_wr_en_out), .stack_rd_en_out(stack_rd_en_out),
    .op_code_in(op_code_in), .op_operand_in(op_operand_in),
    .push_data_in(push_data_in), .stack_addr_out(stack_addr_out),
    .stack_wr_data_out(stack_wr_data_out), .bank_base_out(bank_base_out),
    .mul_div_high_out(mul_div_high_out),
    .stack_top_pointer_out(stack_top_pointer_out),
    .program_status_word_out(program_status_word_out),
    .arith_result_reg_out(arith_result_reg_out),
    .data_pointer_full_out(data_pointer_full_out));

// ===== verif/csp_core_regs_tb.sv
// randomised bench for the core pointer and status registers
`timescale 1ns/1ps
`include "csp_defines.vh"
module testbench;
    reg         clock_in = 1'b0;
    reg         rst_in   = 1'b1;
    reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, opv = 1'b0;
    reg  [9:0]  adr  = 10'h000;
    reg  [31:0] wdat = 32'h0;
    reg  [3:0]  sel  = 4'h0;
    reg  [2:0]  opc  = 3'h0;
    reg  [7:0]  opb  = 8'h00, pdat = 8'h00, q, a, b, p, r;
    reg  [19:0] cx [0:5] = '{20'h17f01, 20'h30001, 20'h41010,
                             20'h4ff01, 20'h55500, 20'h2ff00};
    reg  [7:0]  ix [0:4] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0};
    reg  [7:0]  rv [0:4] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    reg  [7:0]  rs [0:2] = '{8'h97, 8'hce, 8'hdf};
    reg  [7:0]  d  [0:4];
    reg  [2:0]  c;
    reg  [15:0] e;
    wire [31:0] rdat;
    wire        ack, swr, srd;
    wire [7:0]  sadr, swd, bank, sp, program_status_word, acc, mdh;
    wire [15:0] data_pointer_full;
    integer     miscompares = 0, samples_checked = 0, i, k;

    always #20 clock_in = ~clock_in;

    csp_core_regs dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .op_valid_in(opv), .op_code_in(opc),
        .op_operand_in(opb), .push_data_in(pdat), .stack_wr_en_out(swr),
        .stack_rd_en_out(srd), .stack_addr_out(sadr),
        .stack_wr_data_out(swd), .data_pointer_full_out(data_pointer_full),
        .bank_base_out(bank), .stack_top_pointer_out(sp),
        .program_status_word_out(program_status_word), .arith_result_reg_out(acc),
        .mul_div_high_out(mdh));

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // classic cycle; ack and data are read at the falling edge, mid-cycle
    task bus(input w, input [7:0] x, input [7:0] v);
        begin
            @(posedge clock_in);
            cyc  <= 1'b1;
            stb  <= 1'b1;
            we   <= w;
            sel  <= 4'h1;
            adr  <= {x, 2'b00};
            wdat <= {24'h0, v};
            // ack is looked at mid-cycle, where it has settled
            k = 0;
            @(negedge clock_in);
            while (ack !== 1'b1 && k < 16)
            begin
                @(negedge clock_in);
                k = k + 1;
            end
            if (k == 16)
            begin
                miscompares = miscompares + 1;
                give_verdict;
            end
            q = rdat[7:0];
            @(posedge clock_in);
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask

    // one-cycle op pulse, results looked at half a cycle later
    task op(input [2:0] oc, input [7:0] v);
        begin
            @(posedge clock_in);
            opv  <= 1'b1;
            opc  <= oc;
            opb  <= v;
            pdat <= $urandom;
            @(posedge clock_in);
            opv <= 1'b0;
            @(negedge clock_in);
        end
    endtask

    // expected {acc, status} after an arithmetic op
    function [15:0] exp_arith(input [2:0] oc, input [7:0] x, y, s);
        reg [8:0]  t;
        reg [4:0]  n;
        reg [15:0] m;
        reg [7:0]  f;
        reg        ci;
        begin
            f  = s;
            ci = (oc == `CSP_OP_ADD_CARRY || oc == `CSP_OP_SUB_BORROW) & s[7];
            m  = x * y;
            t  = {1'b0, x} + y + ci;
            n  = x[3:0] + y[3:0] + ci;
            f[2] = (x[7] == y[7]) && (t[7] != x[7]);
            if (oc == `CSP_OP_SUB_BORROW)
            begin
                t = {1'b0, x} - y - ci;
                n = {1'b0, x[3:0]} - y[3:0] - ci;
                f[2] = (x[7] != y[7]) && (t[7] != x[7]);
            end
            f[7:6] = {t[8], n[4]};
            if (oc == `CSP_OP_MULTIPLY)
                {t, f[7:6], f[2]} = {1'b0, m[7:0], 2'b00, |m[15:8]};
            if (oc == `CSP_OP_DIVIDE)
                {t, f[7:6], f[2]} = {1'b0, (y == 0) ? x : x / y, 2'b00, y == 0};
            f[0] = ^t[7:0];
            exp_arith = {t[7:0], f};
        end
    endfunction

    initial
    begin
        k = $urandom(32'h16cdca77);
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        for (i = 0; i < 5; i = i + 1)
        begin
            bus(1'b0, ix[i], 8'h00);
            chk(q, rv[i]);
        end
        // random fill, status bit zero always follows the accumulator
        for (i = 0; i < 5; i = i + 1)
        begin
            d[i] = $urandom;
            bus(1'b1, ix[i], d[i]);
        end
        for (i = 0; i < 5; i = i + 1)
        begin
            bus(1'b0, ix[i], 8'h00);
            chk(q, (i == 3) ? {d[3][7:1], ^d[4]} : d[i]);
        end
        chk(data_pointer_full, {d[2], d[1]});
        for (i = 0; i < 4; i = i + 1)
        begin
            bus(1'b1, 8'hd0, {3'h0, i[1:0], 3'h0});
            @(negedge clock_in);
            chk(bank, {3'h0, i[1:0], 3'h0});
        end
        // zeros only, so nothing is set in reserved places
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(1'b1, rs[i], 8'h00);
            bus(1'b0, rs[i], 8'h00);
            chk(q, 8'h00);
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            r = sp;
            op((i < 3) ? `CSP_OP_PUSH : `CSP_OP_POP, 8'h00);
            if (i < 3)
                chk({swr, sadr, swd, sp}, {1'b1, r + 8'h01, pdat, r + 8'h01});
            else
                chk({srd, sadr, sp}, {1'b1, r, r - 8'h01});
        end
        // corner cases first, then random arithmetic
        for (i = 0; i < 40; i = i + 1)
        begin
            c = 3'h1 + $urandom % 5;
            a = $urandom;
            b = $urandom;
            p = $urandom;
            if (i < 6)
                {c, a, b, p} = {cx[i][18:0], 8'h80};
            bus(1'b1, 8'he0, a);
            bus(1'b1, 8'hd0, p);
            op(c, b);
            e = exp_arith(c, a, b, p);
            if (c == `CSP_OP_MULTIPLY)
                chk(mdh, (a * b) >> 8);
            if (c == `CSP_OP_DIVIDE && b != 8'h00)
                chk(mdh, a % b);
            bus(1'b0, 8'he0, 8'h00);
            chk(q, e[15:8]);
            bus(1'b0, 8'hd0, 8'h00);
            chk(q, e[7:0]);
        end
        give_verdict;
    end
endmodule
